// ==== tecg_pin_src.sv ====
// Model of the external source that holds the timer pin when the block does not.
`timescale 1ns/1ps
module tecg_pin_src (
  input wire logic sys_clk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_wire
);
  logic lvl_r = 1'h1;
  // ****************************************
  // Wire level and edge making
  // ****************************************
  // The source yields whenever the block drives, so the two never fight.
  assign pin_wire = pin_oe ? pin_out : lvl_r;
  task automatic set_lvl(input logic v);
    @(negedge sys_clk);
    lvl_r = v;
  endtask : set_lvl
  // Each level lasts four cycles, well below a quarter of the core rate.
  task automatic edges(input int n);
    repeat (2 * n) begin
      set_lvl(!lvl_r);
      repeat (3) @(negedge sys_clk);
    end
  endtask : edges
endmodule : tecg_pin_src

// ==== tecg_pin_sync.sv ====
// Pin synchroniser with edge detection for the timer pin.
`timescale 1ns/1ps
module tecg_pin_sync #(
  parameter int STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output tecg_pkg::tecg_pin_t pin
);
  import tecg_pkg::*;

  generate
    if (STAGES < 2) begin : g_bad_stages
      $error("tecg_pin_sync needs at least two stages.");
    end
  endgenerate

  logic [STAGES-1:0] sync_r;
  logic prev_r;

  // The first stage feeds only the next stage.
  // The chain resets high, the level the sample bit shows after reset, so a pin
  // that idles high gives neither a sample glitch nor a false edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= '1;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], pin_in};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'h1;
    end else begin
      prev_r <= sync_r[STAGES-1];
    end
  end

  assign pin.level = sync_r[STAGES-1];
  assign pin.rise = sync_r[STAGES-1] & ~prev_r;
  assign pin.fall = ~sync_r[STAGES-1] & prev_r;

endmodule : tecg_pin_sync

// ==== tecg_pkg.sv ====
// Constants, field layouts and carrier types of the timer/event counter.
package tecg_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int TECG_W = 24;
  localparam int RUN_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int FLIP_BIT = 2;
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 5;
  localparam int GPIO_BIT = 6;
  localparam int FLAG_BIT = 7;
  localparam int DIR_BIT = 8;
  localparam int SAMPLE_BIT = 9;
  localparam int DRIVE_BIT = 10;
  localparam int RSVD_LSB = 11;

  // ****************************************
  // Word select codes
  // ****************************************
  localparam logic SEL_CTRL = 1'h0;
  localparam logic SEL_RELOAD = 1'h1;

  // ****************************************
  // Mode encodings
  // ****************************************
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PULSE = 3'h1;
  localparam logic [2:0] MODE_TOGGLE = 3'h2;
  localparam logic [2:0] MODE_WIDTH = 3'h4;
  localparam logic [2:0] MODE_PERIOD = 3'h5;
  localparam logic [2:0] MODE_EXT_TIME = 3'h6;
  localparam logic [2:0] MODE_EXT_EVENT = 3'h7;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic SAMPLE_RST = 1'h1;
  localparam logic [TECG_W-1:0] RELOAD_RST = 24'h0;
  localparam logic [1:0] PULSE_CYCLES = 2'h2;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic drive;
    logic dir;
    logic gpio;
    logic [2:0] mode;
    logic flip;
    logic irq_en;
    logic run;
  } tecg_ctrl_t;

  localparam tecg_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tecg_pin_t;

endpackage : tecg_pkg

// ==== tecg_timer.sv ====
// Timer/event counter with one general-purpose capable timer pin.
`timescale 1ns/1ps
module tecg_timer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic soft_rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tecg_pkg::TECG_W-1:0] reg_wdata,
  output logic [tecg_pkg::TECG_W-1:0] reg_rdata,
  input wire logic irq_ack,
  output logic timer_irq,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe
);
  import tecg_pkg::*;

  typedef enum logic {PW_WAIT, PW_COUNT} tecg_pw_t;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'h0;
      rst_sync_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // ****************************************
  // Pin input
  // ****************************************
  tecg_pin_t pin;

  tecg_pin_sync #(
    .STAGES(2)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(timer_pin_in),
    .pin(pin)
  );

  // ****************************************
  // Control word
  // ****************************************
  tecg_ctrl_t ctrl_r;
  tecg_ctrl_t wr_ctrl;
  logic wr_ctrl_en;
  logic wr_reload_en;
  logic rd_ctrl_en;
  logic start;

  assign wr_ctrl_en = reg_wr & (reg_sel == SEL_CTRL);
  assign wr_reload_en = reg_wr & (reg_sel == SEL_RELOAD);
  assign rd_ctrl_en = reg_rd & (reg_sel == SEL_CTRL);

  assign wr_ctrl.run = reg_wdata[RUN_BIT];
  assign wr_ctrl.irq_en = reg_wdata[IRQ_EN_BIT];
  assign wr_ctrl.flip = reg_wdata[FLIP_BIT];
  assign wr_ctrl.mode = reg_wdata[MODE_MSB:MODE_LSB];
  assign wr_ctrl.gpio = reg_wdata[GPIO_BIT];
  assign wr_ctrl.dir = reg_wdata[DIR_BIT];
  assign wr_ctrl.drive = reg_wdata[DRIVE_BIT];

  // A write that turns the run bit on loads the counter.
  assign start = wr_ctrl_en & wr_ctrl.run & ~ctrl_r.run;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (soft_rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl_en) begin
      ctrl_r <= wr_ctrl;
    end
  end

  // ****************************************
  // Half-rate tick
  // ****************************************
  logic half_r;
  logic tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 1'h0;
    end else if (!ctrl_r.run || start) begin
      half_r <= 1'h0;
    end else begin
      half_r <= ~half_r;
    end
  end

  // Internal-clock modes advance on every second core clock.
  assign tick = half_r;

  // ****************************************
  // Edge and level selection
  // ****************************************
  logic sel_edge;
  logic enter_active;
  logic leave_active;

  assign sel_edge = ctrl_r.flip ? pin.fall : pin.rise;
  assign enter_active = ctrl_r.flip ? pin.fall : pin.rise;
  assign leave_active = ctrl_r.flip ? pin.rise : pin.fall;

  // ****************************************
  // Counter
  // ****************************************
  logic [TECG_W-1:0] cnt_r;
  logic [TECG_W-1:0] cnt_nxt;
  logic [TECG_W-1:0] reload_r;
  logic [TECG_W-1:0] cap_val;
  logic cap;
  logic hit;
  tecg_pw_t pw_r;
  tecg_pw_t pw_nxt;
  logic cnt_zero;

  assign cnt_zero = (cnt_r == '0);

  always_comb begin
    cnt_nxt = cnt_r;
    cap = 1'h0;
    cap_val = cnt_r;
    hit = 1'h0;
    pw_nxt = pw_r;
    if (start) begin
      pw_nxt = PW_WAIT;
      if (wr_ctrl.mode == MODE_EXT_TIME) begin
        cnt_nxt = ~reload_r;
      end else begin
        cnt_nxt = reload_r;
      end
    end else if (ctrl_r.run) begin
      case (ctrl_r.mode)
        MODE_TIMER, MODE_PULSE, MODE_TOGGLE: begin
          if (tick) begin
            if (cnt_zero) begin
              hit = 1'h1;
              cnt_nxt = reload_r;
            end else begin
              cnt_nxt = cnt_r - 24'h1;
            end
          end
        end
        MODE_WIDTH: begin
          case (pw_r)
            PW_WAIT: begin
              if (enter_active) begin
                cnt_nxt = '0;
                pw_nxt = PW_COUNT;
              end
            end
            PW_COUNT: begin
              if (leave_active) begin
                hit = 1'h1;
                cap = 1'h1;
                pw_nxt = PW_WAIT;
              end else if (tick) begin
                cnt_nxt = cnt_r + 24'h1;
              end
            end
            default: begin
              pw_nxt = PW_WAIT;
            end
          endcase
        end
        MODE_PERIOD: begin
          if (sel_edge) begin
            hit = 1'h1;
            cap = 1'h1;
          end
          if (tick) begin
            cnt_nxt = cnt_r + 24'h1;
          end
        end
        MODE_EXT_TIME: begin
          if (sel_edge) begin
            cnt_nxt = cnt_r + 24'h1;
            cap = 1'h1;
            cap_val = cnt_r + 24'h1;
            hit = cnt_zero;
          end
        end
        MODE_EXT_EVENT: begin
          if (sel_edge) begin
            if (cnt_zero) begin
              hit = 1'h1;
              cnt_nxt = reload_r;
            end else begin
              cnt_nxt = cnt_r - 24'h1;
            end
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pw_r <= PW_WAIT;
    end else if (soft_rst) begin
      pw_r <= PW_WAIT;
    end else begin
      cnt_r <= cnt_nxt;
      pw_r <= pw_nxt;
    end
  end

  // Hardware capture wins over a software write in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_r <= RELOAD_RST;
    end else if (cap) begin
      reload_r <= cap_val;
    end else if (wr_reload_en) begin
      reload_r <= reg_wdata;
    end
  end

  // ****************************************
  // Zero flag and interrupt
  // ****************************************
  logic flag_r;
  logic irq_r;
  logic clr;

  assign clr = rd_ctrl_en | irq_ack;

  // A new event in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'h0;
    end else if (soft_rst) begin
      flag_r <= 1'h0;
    end else begin
      flag_r <= hit | (flag_r & ~clr);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'h0;
    end else if (soft_rst) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= (hit & ctrl_r.irq_en) | (irq_r & ~clr);
    end
  end

  assign timer_irq = irq_r;

  // ****************************************
  // Pin output
  // ****************************************
  logic [1:0] pulse_cnt_r;
  logic toggle_r;
  logic gpio_mode;
  logic timer_out_mode;
  logic sample_r;
  logic pin_out_r;
  logic pin_oe_r;

  assign gpio_mode = ctrl_r.gpio & (ctrl_r.mode == MODE_TIMER);
  assign timer_out_mode = ctrl_r.run & ((ctrl_r.mode == MODE_PULSE) |
                                        (ctrl_r.mode == MODE_TOGGLE));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_r <= '0;
    end else if (soft_rst || !ctrl_r.run) begin
      pulse_cnt_r <= '0;
    end else if (hit && ctrl_r.mode == MODE_PULSE) begin
      pulse_cnt_r <= PULSE_CYCLES;
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= 1'h0;
    end else if (soft_rst || !ctrl_r.run) begin
      toggle_r <= 1'h0;
    end else if (hit && ctrl_r.mode == MODE_TOGGLE) begin
      toggle_r <= ~toggle_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= 1'h0;
      pin_oe_r <= 1'h0;
    end else if (gpio_mode) begin
      pin_oe_r <= ctrl_r.dir;
      pin_out_r <= ctrl_r.drive ^ ctrl_r.flip;
    end else if (timer_out_mode) begin
      pin_oe_r <= 1'h1;
      if (ctrl_r.mode == MODE_PULSE) begin
        pin_out_r <= (pulse_cnt_r != '0) ^ ctrl_r.flip;
      end else begin
        pin_out_r <= toggle_r ^ ctrl_r.flip;
      end
    end else begin
      pin_oe_r <= 1'h0;
      pin_out_r <= 1'h0;
    end
  end

  assign timer_pin_out = pin_out_r;
  assign timer_pin_oe = pin_oe_r;

  // The sample follows the pin in every mode and direction.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_r <= SAMPLE_RST;
    end else if (soft_rst) begin
      sample_r <= SAMPLE_RST;
    end else begin
      sample_r <= pin.level ^ ctrl_r.flip;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [TECG_W-1:0] ctrl_word;
  logic [TECG_W-1:0] rdata_r;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[RUN_BIT] = ctrl_r.run;
    ctrl_word[IRQ_EN_BIT] = ctrl_r.irq_en;
    ctrl_word[FLIP_BIT] = ctrl_r.flip;
    ctrl_word[MODE_MSB:MODE_LSB] = ctrl_r.mode;
    ctrl_word[GPIO_BIT] = ctrl_r.gpio;
    ctrl_word[FLAG_BIT] = flag_r;
    ctrl_word[DIR_BIT] = ctrl_r.dir;
    ctrl_word[SAMPLE_BIT] = sample_r;
    ctrl_word[DRIVE_BIT] = ctrl_r.drive;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      if (reg_sel == SEL_CTRL) begin
        rdata_r <= ctrl_word;
      end else begin
        rdata_r <= reload_r;
      end
    end
  end

  assign reg_rdata = rdata_r;

endmodule : tecg_timer

// ==== tecg_timer_bench.sv ====
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tecg_timer_bench;
  import tecg_pkg::*;
  logic sys_clk, rst_b, soft_rst, reg_sel, reg_wr, reg_rd, irq_ack;
  logic [TECG_W-1:0] reg_wdata, reg_rdata, r;
  logic timer_irq, pin_out, pin_oe, pin_wire, rd_d = 0, f;
  logic [2*TECG_W-1:0] note, note_q[$];
  int n_fail = 0, num_checks = 0, cyc = 0, n, k, hi, tg;
  tecg_timer i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .soft_rst(soft_rst), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .timer_irq(timer_irq), .timer_pin_in(pin_wire),
    .timer_pin_out(pin_out), .timer_pin_oe(pin_oe));
  tecg_pin_src i_src (.sys_clk(sys_clk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_wire(pin_wire));
  // ****************************************
  // Clock, timeout and read scoreboard
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_d) begin
      note = note_q.pop_front();
      `CHK(reg_rdata & note[2*TECG_W-1:TECG_W], note[TECG_W-1:0])
    end
  end
  task automatic w(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : w
  task automatic wr(input logic s, input logic [TECG_W-1:0] d);
    @(negedge sys_clk);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic s, input logic [TECG_W-1:0] e, input logic [TECG_W-1:0] m);
    @(negedge sys_clk);
    note_q.push_back({m, e & m});
    reg_sel = s;
    reg_rd = 1;
    @(negedge sys_clk);
    reg_rd = 0;
  endtask : rd
  task automatic wait_irq(output int c);
    c = 0;
    while (timer_irq !== 1'b1 && c < 200) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : wait_irq
  task automatic watch(input int len);
    logic p;
    hi = 0;
    tg = 0;
    p = pin_out;
    repeat (len) begin
      @(negedge sys_clk);
      hi += int'((pin_out ^ f) === 1'b1);
      tg += int'(pin_out !== p);
      p = pin_out;
    end
  endtask : watch
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    {soft_rst, reg_sel, reg_wr, reg_rd, irq_ack} = '0;
    reg_wdata = '0;
    void'($urandom(36));
    w(8);
    rst_b = 1;
    w(3);
    rd(SEL_CTRL, 24'h000200, '1);
    rd(SEL_RELOAD, RELOAD_RST, '1);
    r = 24'($urandom()) & 24'h000506 | 24'hfff800;
    wr(SEL_CTRL, r);
    w(6);
    `CHK(pin_oe, 1'b0)
    rd(SEL_CTRL, (r & 24'h000506) | (24'(!r[FLIP_BIT]) << SAMPLE_BIT), '1);
    // General-purpose use only with mode zero, whether or not the timer runs; the loop keeps it stopped.
    for (int i = 0; i < 8; i++) begin
      f = i[0];
      i_src.set_lvl(i[1]);
      wr(SEL_CTRL, 24'(i[1]) << 10 | 24'(i[2]) << 8 | 24'h40 | 24'(f) << 2);
      w(6);
      `CHK(pin_oe, i[2])
      if (i[2]) `CHK(pin_out, i[1] ^ f)
      rd(SEL_CTRL, 24'(i[2] ? i[1] : i[1] ^ f) << 9, 24'h200);
    end
    wr(SEL_CTRL, 24'h0);
    i_src.set_lvl(1);
    n = 2 + $urandom_range(5);
    wr(SEL_RELOAD, 24'(n));
    wr(SEL_CTRL, 24'h000003);
    wait_irq(k);
    @(negedge sys_clk) irq_ack = 1;
    @(negedge sys_clk) irq_ack = 0;
    `CHK(timer_irq, 1'b0)
    wait_irq(k);
    `CHK(k, 2 * n)
    rd(SEL_CTRL, 24'h80, 24'h80);
    `CHK(timer_irq, 1'b0)
    wr(SEL_CTRL, 24'h000001);
    w(2 * n + 6);
    `CHK(timer_irq, 1'b0)
    rd(SEL_CTRL, 24'h80, 24'h80);
    for (int m = 1; m <= 2; m++) begin
      f = $urandom_range(1);
      wr(SEL_CTRL, 24'h0);
      wr(SEL_CTRL, 24'(m) << 3 | 24'(f) << 2 | 24'h1);
      w(2 * n + 8);
      `CHK(pin_oe, 1'b1)
      watch(6 * (n + 1));
      `CHK(m == 1 ? hi : tg, m == 1 ? 6 : 3)
    end
    for (int g = 0; g < 2; g++) begin
      f = g[0];
      wr(SEL_CTRL, 24'h0);
      // Let a pin just released by the block settle before edges are counted.
      w(6);
      wr(SEL_CTRL, 24'h3b | 24'(f) << 2);
      i_src.edges(n);
      w(6);
      `CHK(timer_irq, 1'b0)
      i_src.set_lvl(0);
      w(6);
      `CHK(timer_irq, f)
      i_src.set_lvl(1);
      w(6);
      `CHK(timer_irq, 1'b1)
      rd(SEL_CTRL, 24'h80, 24'h80);
    end
    wr(SEL_CTRL, 24'h0);
    r = 24'($urandom()) | 24'h10;
    wr(SEL_RELOAD, r);
    wr(SEL_CTRL, 24'h31);
    i_src.edges(3);
    w(6);
    rd(SEL_RELOAD, ~r + 24'h3, '1);
    wr(SEL_CTRL, 24'h0);
    wr(SEL_CTRL, 24'h27);
    i_src.set_lvl(0);
    w(20);
    `CHK(timer_irq, 1'b0)
    i_src.set_lvl(1);
    w(6);
    `CHK(timer_irq, 1'b1)
    rd(SEL_RELOAD, 24'ha, '1);
    wr(SEL_CTRL, 24'h19);
    w(4);
    `CHK(pin_oe, 1'b0)
    rd(SEL_CTRL, 24'h299, '1);
    wr(SEL_CTRL, 24'h0);
    wr(SEL_RELOAD, 24'h100);
    wr(SEL_CTRL, 24'h2b);
    i_src.set_lvl(0);
    w(6);
    `CHK(timer_irq, 1'b0)
    i_src.set_lvl(1);
    w(6);
    `CHK(timer_irq, 1'b1)
    rd(SEL_RELOAD, 24'h100, 24'hfffff8);
    @(negedge sys_clk) soft_rst = 1;
    @(negedge sys_clk) soft_rst = 0;
    `CHK(timer_irq, 1'b0)
    w(6);
    rd(SEL_CTRL, 24'h000200, '1);
    w(2);
    give_verdict();
  end
endmodule : tecg_timer_bench

// ==== tecg_timer_chk.sv ====
// Port-level assertions for the timer block, bound into its top module.
`timescale 1ns/1ps
module tecg_timer_chk
  import tecg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic soft_rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [TECG_W-1:0] reg_wdata,
  input wire logic [TECG_W-1:0] reg_rdata,
  input wire logic irq_ack,
  input wire logic timer_irq,
  input wire logic timer_pin_in,
  input wire logic timer_pin_out,
  input wire logic timer_pin_oe
);
  tecg_ctrl_t ctl_r;
  logic [TECG_W-1:0] rl_r;
  logic rl_ok_r;
  logic [2:0] cst_r;
  logic pin_d_r;
  logic clr;
  assign clr = irq_ack || soft_rst || (reg_rd && !reg_sel);
  // ****************************************
  // Shadow of written control and reload values
  // ****************************************
  // Capture modes may rewrite the reload word, so its shadow is trusted only after reset or after a write.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= CTRL_RST;
      rl_r <= RELOAD_RST;
      rl_ok_r <= 1'h1;
    end else begin
      if (soft_rst) begin
        ctl_r <= CTRL_RST;
      end else if (reg_wr && !reg_sel) begin
        ctl_r <= {reg_wdata[DRIVE_BIT], reg_wdata[DIR_BIT], reg_wdata[GPIO_BIT:RUN_BIT]};
      end
      if (reg_wr && reg_sel) begin
        rl_r <= reg_wdata;
      end
      if (ctl_r.mode[2]) begin
        rl_ok_r <= 1'h0;
      end else if (reg_wr && reg_sel) begin
        rl_ok_r <= 1'h1;
      end
    end
  end
  // Counts quiet cycles of pin and control word, so the sampled pin has settled.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cst_r <= 3'h0;
      pin_d_r <= 1'h1;
    end else begin
      pin_d_r <= timer_pin_in;
      if (soft_rst || (reg_wr && !reg_sel) || timer_pin_in != pin_d_r) begin
        cst_r <= 3'h0;
      end else if (cst_r != 3'h7) begin
        cst_r <= cst_r + 3'h1;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_rsvd_read_zero: assert property (
    reg_rd && !reg_sel |=> reg_rdata[TECG_W-1:RSVD_LSB] == '0)
    else $error("reserved control bits read nonzero");
  a_irq_drop_cause: assert property (
    $fell(timer_irq) |-> $past(clr))
    else $error("interrupt dropped without read, acknowledge or reset");
  a_irq_needs_en: assert property (
    $rose(timer_irq) |-> $past(ctl_r.irq_en))
    else $error("interrupt raised while disabled");
  a_gpio_pin_ctl: assert property (
    ctl_r.mode == MODE_TIMER && $stable(ctl_r) |-> timer_pin_oe == (ctl_r.gpio && ctl_r.dir)
    && (!timer_pin_oe || timer_pin_out == (ctl_r.drive ^ ctl_r.flip)))
    else $error("general-purpose pin drive wrong");
  a_input_no_drive: assert property (
    (ctl_r.mode[2] || ctl_r.mode == 3'h3) && $stable(ctl_r) |-> !timer_pin_oe)
    else $error("pin driven in an input or reserved mode");
  a_sample_follows: assert property (
    reg_rd && !reg_sel && cst_r == 3'h7
    |=> reg_rdata[SAMPLE_BIT] == ($past(timer_pin_in) ^ $past(ctl_r.flip)))
    else $error("pin sample bit wrong");
  a_pulse_two_wide: assert property (
    ctl_r.run && ctl_r.mode == MODE_PULSE && $stable(ctl_r) && $rose(timer_pin_out ^ ctl_r.flip)
    |=> (timer_pin_out ^ ctl_r.flip) ##1 !(timer_pin_out ^ ctl_r.flip))
    else $error("output pulse not two cycles wide");
  a_reload_keeps: assert property (
    reg_rd && reg_sel && !reg_wr && rl_ok_r |=> reg_rdata == $past(rl_r))
    else $error("reload word differs from last write");
endmodule : tecg_timer_chk

bind tecg_timer tecg_timer_chk i_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .soft_rst(soft_rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
  .timer_irq(timer_irq), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
  .timer_pin_oe(timer_pin_oe)
);
